//--- design/tmr_edge_sync.sv
`timescale 1ns/10ps
// ==========================================================================
// oscillator input: two-stage synchroniser and rising edge pulse
module tmr_edge_sync (
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic levelIn, // slow oscillator level
  output logic risePulse // one cycle per rising edge
);
  import tmr_pkg::*;

  typedef struct packed {
    logic stage1;
    logic stage2;
    logic prev;
    logic rise;
  } tmr_edge_t;

  tmr_edge_t q;
  tmr_edge_t d;

  // ========================================================================
  // stage1 feeds stage2 only, edge is taken after the second stage
  always_comb begin
    d = q;
    d.stage1 = levelIn;
    d.stage2 = q.stage1;
    d.prev = q.stage2;
    d.rise = q.stage2 & ~q.prev;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign risePulse = q.rise;

endmodule : tmr_edge_sync

//--- design/tmr_prescaler.sv
`timescale 1ns/10ps
// ==========================================================================
// prescaler: turns source ticks into the selected timer tick
module tmr_prescaler (
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic srcTick, // source clock enable
  input wire logic [2:0] clockSel, // clock select field
  output logic timerTick // one cycle timer enable
);
  import tmr_pkg::*;

  typedef struct packed {
    logic [9:0] count;
    logic tick;
  } tmr_pre_t;

  tmr_pre_t q;
  tmr_pre_t d;
  logic [9:0] mask;

  // ========================================================================
  // free-running divider; all taps share one counter so they stay in phase
  always_comb begin
    d = q;
    d.tick = 1'b0;
    mask = MASK_DIV1024;
    case (clockSel)
      CS_DIV8: mask = MASK_DIV8;
      CS_DIV32: mask = MASK_DIV32;
      CS_DIV64: mask = MASK_DIV64;
      CS_DIV128: mask = MASK_DIV128;
      CS_DIV256: mask = MASK_DIV256;
      default: mask = MASK_DIV1024;
    endcase
    if (srcTick) begin
      d.count = q.count + 10'h001;
      case (clockSel)
        CS_STOP: d.tick = 1'b0;
        CS_DIV1: d.tick = 1'b1;
        default: d.tick = ((q.count & mask) == mask);
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign timerTick = q.tick;

endmodule : tmr_prescaler

//--- design/tmr_timer.sv
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
// ==========================================================================
// 8-bit timer with compare output pin, prescaler and async holding regs

module tmr_timer (
  input wire logic clk, // 250 MHz system clock
  input wire logic rstn, // async reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic crystalOscInput, // crystal oscillator level
  input wire logic portPinData, // ordinary port function level
  output logic compareOutputPin, // level routed to the pin
  output logic compareOutputOverride, // timer owns the pin
  output logic compareMatchEvent // one cycle per compare match
);
  import tmr_pkg::*;

  typedef struct packed {
    tmr_wr_state_t wrState;
    logic awHeld;
    logic [7:0] awAddr;
    logic wHeld;
    logic [7:0] wData;
    logic wStrb;
    logic [1:0] bResp;
    logic rValid;
    logic [7:0] rData;
    logic [1:0] rResp;
    logic [7:0] ctlHold;
    logic [7:0] ctlAct;
    logic [7:0] cntVal;
    logic [7:0] cntHold;
    logic [7:0] cmpHold;
    logic [7:0] cmpReg;
    logic [7:0] cmpUsed;
    logic asyncSel;
    logic [2:0] busy;
    logic [2:0][1:0] edgeCnt;
    logic forcePend;
    logic blockMatch;
    logic countDown;
    logic ocLevel;
    logic matchPulse;
  } tmr_core_t;

  localparam tmr_core_t CORE_RESET = '{
    wrState: WR_COLLECT,
    ctlHold: RST_CONTROL,
    ctlAct: RST_CONTROL,
    cntVal: RST_COUNTER,
    cntHold: RST_COUNTER,
    cmpHold: RST_COMPARE,
    cmpReg: RST_COMPARE,
    cmpUsed: RST_COMPARE,
    asyncSel: RST_ASYNC_SEL,
    default: '0
  };

  tmr_core_t q;
  tmr_core_t d;

  logic oscRise;
  logic srcTick;
  logic timerTick;
  tmr_wave_t wave;
  logic [1:0] com;
  logic isPwm;
  logic match;
  logic topEvent;
  logic cmpAtTop;
  logic upMatch;
  logic [7:0] wrValue;

  // ========================================================================
  // oscillator edge detection and prescaler
  tmr_edge_sync u_osc (
    .clk(clk),
    .rstn(rstn),
    .levelIn(crystalOscInput),
    .risePulse(oscRise)
  );

  // source is the system clock or the oscillator edge
  assign srcTick = q.asyncSel ? oscRise : 1'b1;

  tmr_prescaler u_pre (
    .clk(clk),
    .rstn(rstn),
    .srcTick(srcTick),
    .clockSel(q.ctlAct[CTL_CS_LSB +: 3]),
    .timerTick(timerTick)
  );

  // ========================================================================
  // decoded control fields from the active control register
  assign wave = tmr_wave_t'({q.ctlAct[CTL_WAVE1_BIT], q.ctlAct[CTL_WAVE0_BIT]});
  assign com = q.ctlAct[CTL_COM_LSB +: 2];
  assign isPwm = (wave == WAVE_PHASE) || (wave == WAVE_FAST);
  assign match = (q.cntVal == q.cmpUsed) && !q.blockMatch;
  assign cmpAtTop = (q.cmpUsed == TOP_VALUE);
  assign upMatch = !q.countDown || (q.cntVal == BOTTOM_VALUE);
  assign wrValue = q.wData;

  // top is the last count before wrap or the turning point
  always_comb begin
    case (wave)
      WAVE_FAST: topEvent = (q.cntVal == TOP_VALUE);
      WAVE_PHASE: topEvent = (q.cntVal == TOP_VALUE) && !q.countDown;
      default: topEvent = 1'b0;
    endcase
  end

  // ========================================================================
  // next state: timer, transfers, then bus (later code wins a conflict)
  always_comb begin
    d = q;
    d.matchPulse = 1'b0;

    // counting and pin actions on each timer tick
    if (timerTick) begin
      d.blockMatch = 1'b0;
      d.matchPulse = match;
      case (wave)
        WAVE_CTC: d.cntVal = match ? BOTTOM_VALUE : q.cntVal + 8'h01;
        WAVE_PHASE: begin
          if (!q.countDown && q.cntVal == TOP_VALUE) begin
            d.countDown = 1'b1;
            d.cntVal = q.cntVal - 8'h01;
          end else if (q.countDown && q.cntVal == BOTTOM_VALUE) begin
            d.countDown = 1'b0;
            d.cntVal = q.cntVal + 8'h01;
          end else begin
            d.cntVal = q.countDown ? q.cntVal - 8'h01 : q.cntVal + 8'h01;
          end
        end
        default: d.cntVal = q.cntVal + 8'h01;
      endcase
      // double buffer: pwm modes take a new compare value only at top
      if (isPwm && topEvent) begin
        d.cmpUsed = q.cmpReg;
      end
      if (!isPwm) begin
        if (match) begin
          case (com)
            COM_TOGGLE: d.ocLevel = ~q.ocLevel;
            COM_CLEAR: d.ocLevel = 1'b0;
            COM_SET: d.ocLevel = 1'b1;
            default: d.ocLevel = q.ocLevel;
          endcase
        end
      end else if (com[1]) begin
        if (match && !cmpAtTop) begin
          if (wave == WAVE_FAST) begin
            d.ocLevel = (com == COM_SET);
          end else begin
            d.ocLevel = upMatch ? (com == COM_SET) : (com == COM_CLEAR);
          end
        end
        if (topEvent && (wave == WAVE_FAST || cmpAtTop)) begin
          d.ocLevel = (com == COM_CLEAR);
        end
      end
    end

    // non-pwm modes follow the compare register at once
    if (!isPwm) begin
      d.cmpUsed = d.cmpReg;
    end

    // async transfers: each holding register counts its own edges
    if (q.asyncSel && oscRise) begin
      for (int i = 0; i < 3; i++) begin
        if (q.busy[i]) begin
          if (q.edgeCnt[i] == XFER_EDGES - 2'h1) begin
            d.busy[i] = 1'b0;
            d.edgeCnt[i] = 2'h0;
          end else begin
            d.edgeCnt[i] = q.edgeCnt[i] + 2'h1;
          end
        end
      end
      if (q.busy[ASY_CNT_BUSY_BIT] && q.edgeCnt[ASY_CNT_BUSY_BIT] == XFER_EDGES - 2'h1) begin
        d.cntVal = q.cntHold;
        d.blockMatch = 1'b1;
      end
      if (q.busy[ASY_CMP_BUSY_BIT] && q.edgeCnt[ASY_CMP_BUSY_BIT] == XFER_EDGES - 2'h1) begin
        d.cmpReg = q.cmpHold;
      end
      if (q.busy[ASY_CTL_BUSY_BIT] && q.edgeCnt[ASY_CTL_BUSY_BIT] == XFER_EDGES - 2'h1) begin
        d.ctlAct = q.ctlHold;
      end
    end

    // in non-pwm modes a force strobe acts like a match with the now active output mode
    if (q.forcePend && !d.busy[ASY_CTL_BUSY_BIT]) begin
      d.forcePend = 1'b0;
      if (!(d.ctlAct[CTL_WAVE0_BIT])) begin
        case (d.ctlAct[CTL_COM_LSB +: 2])
          COM_TOGGLE: d.ocLevel = ~d.ocLevel;
          COM_CLEAR: d.ocLevel = 1'b0;
          COM_SET: d.ocLevel = 1'b1;
          default: d.ocLevel = d.ocLevel;
        endcase
      end
    end

    // write channel: address and data are taken in either order
    case (q.wrState)
      WR_COLLECT: begin
        if (s_axi_awvalid && !q.awHeld) begin
          d.awHeld = 1'b1;
          d.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !q.wHeld) begin
          d.wHeld = 1'b1;
          d.wData = s_axi_wdata[7:0];
          d.wStrb = s_axi_wstrb[0];
        end
        if (d.awHeld && d.wHeld) begin
          d.wrState = WR_APPLY;
        end
      end
      WR_APPLY: begin
        d.awHeld = 1'b0;
        d.wHeld = 1'b0;
        d.bResp = RESP_OKAY;
        d.wrState = WR_RESPOND;
        case (q.awAddr)
          OFS_CONTROL: begin
            if (q.wStrb) begin
              d.ctlHold = {1'b0, wrValue[6:0]};
              d.forcePend = wrValue[CTL_FORCE_BIT];
              if (q.asyncSel) begin
                d.busy[ASY_CTL_BUSY_BIT] = 1'b1;
                d.edgeCnt[ASY_CTL_BUSY_BIT] = 2'h0;
              end else begin
                d.ctlAct = {1'b0, wrValue[6:0]};
              end
            end
          end
          OFS_COUNTER: begin
            if (q.wStrb) begin
              d.cntHold = wrValue;
              if (q.asyncSel) begin
                d.busy[ASY_CNT_BUSY_BIT] = 1'b1;
                d.edgeCnt[ASY_CNT_BUSY_BIT] = 2'h0;
              end else begin
                d.cntVal = wrValue;
                d.blockMatch = 1'b1;
              end
            end
          end
          OFS_COMPARE: begin
            if (q.wStrb) begin
              d.cmpHold = wrValue;
              if (q.asyncSel) begin
                d.busy[ASY_CMP_BUSY_BIT] = 1'b1;
                d.edgeCnt[ASY_CMP_BUSY_BIT] = 2'h0;
              end else begin
                d.cmpReg = wrValue;
              end
            end
          end
          OFS_ASYNC: begin
            // switching source can leave the three registers corrupt
            if (q.wStrb) begin
              d.asyncSel = wrValue[ASY_SEL_BIT];
            end
          end
          default: d.bResp = RESP_SLVERR;
        endcase
      end
      WR_RESPOND: begin
        if (s_axi_bready) begin
          d.wrState = WR_COLLECT;
        end
      end
      default: d.wrState = WR_COLLECT;
    endcase

    // read channel: one read at a time, answer on the next cycle
    if (q.rValid && s_axi_rready) begin
      d.rValid = 1'b0;
    end
    if (!q.rValid && s_axi_arvalid) begin
      d.rValid = 1'b1;
      d.rResp = RESP_OKAY;
      case (s_axi_araddr)
        OFS_CONTROL: d.rData = q.ctlHold;
        OFS_COUNTER: d.rData = q.cntVal;
        OFS_COMPARE: d.rData = q.cmpHold;
        OFS_ASYNC: d.rData = {4'h0, q.asyncSel, q.busy};
        default: begin
          d.rData = 8'h00;
          d.rResp = RESP_SLVERR;
        end
      endcase
    end
  end

  // ========================================================================
  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= CORE_RESET;
    end else begin
      q <= d;
    end
  end

  // ========================================================================
  // bus handshakes and data
  assign s_axi_awready = (q.wrState == WR_COLLECT) && !q.awHeld;
  assign s_axi_wready = (q.wrState == WR_COLLECT) && !q.wHeld;
  assign s_axi_bvalid = (q.wrState == WR_RESPOND);
  assign s_axi_bresp = q.bResp;
  assign s_axi_arready = !q.rValid;
  assign s_axi_rvalid = q.rValid;
  assign s_axi_rdata = {24'h000000, q.rData};
  assign s_axi_rresp = q.rResp;

  // ========================================================================
  // pin: the driver still needs the direction bit set outside
  assign compareOutputOverride = (com != COM_OFF);
  assign compareOutputPin = compareOutputOverride ? q.ocLevel : portPinData;
  assign compareMatchEvent = q.matchPulse;

endmodule : tmr_timer

//--- inc/tmr_pkg.sv
// ==========================================================================
// shared constants of the asynchronous 8-bit compare timer
package tmr_pkg;

  // ========================================================================
  // register byte addresses on the bus
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_COUNTER = 8'h04;
  localparam logic [7:0] OFS_COMPARE = 8'h08;
  localparam logic [7:0] OFS_ASYNC = 8'h0C;

  // ========================================================================
  // field positions, timer control register
  localparam int CTL_FORCE_BIT = 7;
  localparam int CTL_WAVE0_BIT = 6;
  localparam int CTL_COM_LSB = 4;
  localparam int CTL_WAVE1_BIT = 3;
  localparam int CTL_CS_LSB = 0;

  // field positions, async status register
  localparam int ASY_SEL_BIT = 3;
  localparam int ASY_CNT_BUSY_BIT = 2;
  localparam int ASY_CMP_BUSY_BIT = 1;
  localparam int ASY_CTL_BUSY_BIT = 0;

  // ========================================================================
  // reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_COUNTER = 8'h00;
  localparam logic [7:0] RST_COMPARE = 8'h00;
  localparam logic RST_ASYNC_SEL = 1'b0;

  // ========================================================================
  // timing: oscillator edges before a held value lands
  localparam logic [1:0] XFER_EDGES = 2'h2;

  // ========================================================================
  // counter limits
  localparam logic [7:0] TOP_VALUE = 8'hFF;
  localparam logic [7:0] BOTTOM_VALUE = 8'h00;

  // ========================================================================
  // waveform modes, compare output modes, clock selections
  typedef enum logic [1:0] {
    WAVE_NORMAL = 2'h0,
    WAVE_PHASE = 2'h1,
    WAVE_CTC = 2'h2,
    WAVE_FAST = 2'h3
  } tmr_wave_t;

  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV32 = 3'h3;
  localparam logic [2:0] CS_DIV64 = 3'h4;
  localparam logic [2:0] CS_DIV128 = 3'h5;
  localparam logic [2:0] CS_DIV256 = 3'h6;
  localparam logic [2:0] CS_DIV1024 = 3'h7;

  // prescaler masks: divide by n ticks when the low bits are all ones
  localparam logic [9:0] MASK_DIV8 = 10'h007;
  localparam logic [9:0] MASK_DIV32 = 10'h01F;
  localparam logic [9:0] MASK_DIV64 = 10'h03F;
  localparam logic [9:0] MASK_DIV128 = 10'h07F;
  localparam logic [9:0] MASK_DIV256 = 10'h0FF;
  localparam logic [9:0] MASK_DIV1024 = 10'h3FF;

  // ========================================================================
  // bus answers and the write-side state machine
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    WR_COLLECT = 3'b001,
    WR_APPLY = 3'b010,
    WR_RESPOND = 3'b100
  } tmr_wr_state_t;

endpackage : tmr_pkg

//--- verification/tmr_timer_monitor.sv
`timescale 1ns/10ps
// ==========================================================================
// port-level checks of the compare timer
module tmr_timer_monitor (
  input wire logic clk, // clock
  input wire logic rstn, // reset, active low
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic [1:0] s_axi_bresp, // write answer
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic portPinData, // port level
  input wire logic compareOutputPin, // pin level
  input wire logic compareOutputOverride // timer owns pin
);
  import tmr_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ========================================================================
  // write: both halves taken, one apply cycle, then the answer
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_answer;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  a_write_answer: assert property (s_wr_take |=> s_wr_answer)
    else $error("write answer not two cycles after take");
  a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  // ========================================================================
  // read answer one cycle after the address, held until taken
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before taken");
  a_rdata_width: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data wider than a byte");
  // ========================================================================
  // pin ownership
  a_pin_release: assert property (!compareOutputOverride |-> compareOutputPin == portPinData)
    else $error("released pin not following port level");
  a_reset_release: assert property ($rose(rstn) |-> !compareOutputOverride)
    else $error("pin owned right after reset");
endmodule : tmr_timer_monitor

//--- verification/tmr_timer_tb.sv
`timescale 1ns/10ps
// ==========================================================================
// register-level test of the compare timer
module tmr_timer_tb;
  import tmr_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic crystalOscInput = 1'b0;
  logic portPinData = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic compareOutputPin, compareOutputOverride, compareMatchEvent;
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;
  int oscCnt = 0;
  int div [7] = '{1, 8, 32, 64, 128, 256, 1024};
  logic [1:0] coms [4] = '{COM_SET, COM_CLEAR, COM_SET, COM_TOGGLE};
  logic exps [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

  tmr_timer dut (.clk(clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .crystalOscInput(crystalOscInput), .portPinData(portPinData),
    .compareOutputPin(compareOutputPin), .compareOutputOverride(compareOutputOverride),
    .compareMatchEvent(compareMatchEvent));

  always #2 clk = ~clk;
  // crystal runs free, 40 clocks a period, well over four clocks a cycle
  always @(posedge clk) begin
    oscCnt <= (oscCnt == 19) ? 0 : oscCnt + 1;
    if (oscCnt == 19) crystalOscInput <= ~crystalOscInput;
  end
  // watchdog on the whole run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // one bus write; halves released as each is taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check($sformatf("bresp@%h", a), {30'h0, s_axi_bresp}, {30'h0, er});
  endtask : wr

  // one bus read compared with the expected byte
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er = RESP_OKAY);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    check($sformatf("rdata@%h", a), s_axi_rdata, {24'h000000, e});
    check($sformatf("rresp@%h", a), {30'h0, s_axi_rresp}, {30'h0, er});
  endtask : rc

  task automatic wait_ev(input int lim, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (compareMatchEvent !== 1'b1 && n < lim);
  endtask : wait_ev

  task automatic pin(input int w, input logic e, input string nm);
    repeat (w) @(posedge clk);
    check(nm, {31'h0, compareOutputPin}, {31'h0, e});
  endtask : pin

  function automatic logic [7:0] ctl(input logic [1:0] w, input logic [1:0] c, input logic [2:0] s);
    ctl = 8'h00;
    ctl[CTL_WAVE0_BIT] = w[0];
    ctl[CTL_WAVE1_BIT] = w[1];
    ctl[CTL_COM_LSB+:2] = c;
    ctl[CTL_CS_LSB+:3] = s;
  endfunction : ctl

  // ========================================================================
  // main sequence
  initial begin
    int n;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 4; i++) rc(8'(i * 4), 8'h00);
    rc(8'h10, 8'h00, RESP_SLVERR);
    wr(8'h14, 8'hFF, RESP_SLVERR);
    wr(OFS_CONTROL, 8'h80);
    rc(OFS_CONTROL, 8'h00);
    portPinData <= 1'b1;
    pin(2, 1'b1, "pinPort");
    portPinData <= 1'b0;
    pin(2, 1'b0, "pinPort");
    // non-pwm actions on a running counter
    wr(OFS_COMPARE, 8'h40);
    wr(OFS_COUNTER, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CONTROL, ctl(WAVE_NORMAL, coms[i], CS_DIV1));
      wait_ev(600, n);
      pin(3, exps[i], "pinNormal");
      check("override", {31'h0, compareOutputOverride}, 32'h1);
    end
    // loading the counter hides the next match
    wr(OFS_COUNTER, 8'h40);
    wait_ev(100, n);
    check("noMatch", n, 100);
    // fast pwm, then compare at top
    wr(OFS_COMPARE, 8'h80);
    for (int j = 0; j < 2; j++) begin
      wr(OFS_CONTROL, ctl(WAVE_FAST, 2'(2 + j), CS_DIV1));
      wait_ev(600, n);
      pin(3, 1'(j), "pinFastMatch");
      pin(150, !1'(j), "pinFastTop");
    end
    wr(OFS_COMPARE, 8'hFF);
    wr(OFS_CONTROL, ctl(WAVE_FAST, COM_CLEAR, CS_DIV1));
    pin(300, 1'b1, "pinAtTop");
    pin(130, 1'b1, "pinAtTop");
    // phase correct from a stopped counter: first match counts up
    wr(OFS_CONTROL, ctl(WAVE_NORMAL, COM_OFF, CS_STOP));
    wr(OFS_COMPARE, 8'h80);
    wr(OFS_COUNTER, 8'h00);
    wr(OFS_CONTROL, ctl(WAVE_PHASE, COM_CLEAR, CS_DIV1));
    wait_ev(600, n);
    pin(3, 1'b0, "pinUp");
    wait_ev(600, n);
    pin(3, 1'b1, "pinDown");
    // phase mode, compare at top: match ignored, inverted mode clears at top
    wr(OFS_CONTROL, ctl(WAVE_PHASE, COM_SET, CS_DIV1));
    wr(OFS_COMPARE, 8'hFF);
    pin(1000, 1'b0, "pinPhaseTop");
    // each tap: ctc with compare 1 matches every second tick
    wr(OFS_CONTROL, ctl(WAVE_NORMAL, COM_OFF, CS_STOP));
    wr(OFS_COMPARE, 8'h01);
    wr(OFS_COUNTER, 8'h00);
    for (int i = 0; i < 7; i++) begin
      wr(OFS_CONTROL, ctl(WAVE_CTC, COM_OFF, 3'(i + 1)));
      wait_ev(5000, n);
      wait_ev(5000, n);
      check("period", n, 2 * div[i]);
    end
    wr(OFS_CONTROL, ctl(WAVE_CTC, COM_OFF, CS_STOP));
    wait_ev(100, n);
    check("stopped", n, 100);
    // force strobe toggles at once and reads back as zero
    wr(OFS_CONTROL, 8'h80 | ctl(WAVE_CTC, COM_TOGGLE, CS_STOP));
    pin(2, 1'b1, "pinForce");
    rc(OFS_CONTROL, 8'h18);
    wr(OFS_CONTROL, ctl(WAVE_CTC, COM_OFF, CS_STOP));
    // asynchronous holding registers and busy flags
    wr(OFS_COUNTER, 8'h22);
    wr(OFS_ASYNC, 8'h08);
    rc(OFS_ASYNC, 8'h08);
    wr(OFS_COMPARE, 8'h33);
    rc(OFS_ASYNC, 8'h0A);
    rc(OFS_COMPARE, 8'h33);
    wr(OFS_COUNTER, 8'h11);
    rc(OFS_ASYNC, 8'h0E);
    rc(OFS_COUNTER, 8'h22);
    repeat (200) @(posedge clk);
    rc(OFS_ASYNC, 8'h08);
    rc(OFS_COUNTER, 8'h11);
    wr(OFS_CONTROL, 8'h30);
    rc(OFS_ASYNC, 8'h09);
    rc(OFS_CONTROL, 8'h30);
    check("override", {31'h0, compareOutputOverride}, 32'h0);
    repeat (200) @(posedge clk);
    rc(OFS_ASYNC, 8'h08);
    check("override", {31'h0, compareOutputOverride}, 32'h1);
    finish_test();
  end
endmodule : tmr_timer_tb

bind tmr_timer tmr_timer_monitor u_mon (.clk(clk), .rstn(rstn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .portPinData(portPinData), .compareOutputPin(compareOutputPin),
  .compareOutputOverride(compareOutputOverride));
